// File: rtl/dpwm_top.sv
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module dpwm_top
    import dpwm_pkg::*;
(
    input  wire logic                       clock,
    input  wire logic                       reset_n,
    input  wire logic [dpwm_pkg::ADDR_W-1:0] addr,
    input  wire logic [dpwm_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic [dpwm_pkg::DATA_W-1:0]     rdata,
    output logic [dpwm_pkg::NUM_CH-1:0]     pwm_out,
    output logic                            irq
);
    logic [CNT_W-1:0]  high_m1 [NUM_CH];
    logic [CNT_W-1:0]  low_m1  [NUM_CH];
    logic [CNT_W-1:0]  period  [NUM_CH];
    logic [CNT_W-1:0]  count   [NUM_CH];
    logic [2:0]        ctrl    [NUM_CH];
    logic [NUM_CH-1:0] level;
    logic [NUM_CH-1:0] evt;
    logic [NUM_CH-1:0] pending;
    logic [NUM_CH-1:0] sel;
    logic [NUM_CH-1:0] live;
    logic [7:0]        off;
    logic [DATA_W-1:0] next_rdata;

    assign off = {3'h0, addr[4:0]};

    // one register block and counter per channel
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        assign sel[c]  = (addr[7:5] == 3'(c));
        assign live[c] = pending[c] && !ctrl[c][CTRL_MASK];

        // timing registers
        always_ff @(posedge clock) begin
            if (!reset_n) begin
                high_m1[c] <= RST_HIGH;
                low_m1[c]  <= RST_LOW;
                period[c]  <= RST_PERIOD;
            end else if (wr && sel[c]) begin
                if (off == OFF_HIGH) high_m1[c] <= wdata;
                if (off == OFF_LOW) low_m1[c] <= wdata;
                if (off == OFF_PERIOD) period[c] <= wdata;
            end
        end

        dpwm_regs u_regs (
            .clock    (clock),
            .reset_n  (reset_n),
            .wr_en    (wr && sel[c] && off == OFF_CTRL),
            .wdata    (wdata),
            .event_in (evt[c]),
            .clear_rd (rd && sel[c] && off == OFF_EOI),
            .ctrl     (ctrl[c]),
            .pending  (pending[c])
        );

        dpwm_channel u_chan (
            .clock       (clock),
            .reset_n     (reset_n),
            .enable      (ctrl[c][CTRL_EN]),
            .timer_mode  (ctrl[c][CTRL_TIMER]),
            .high_m1     (high_m1[c]),
            .low_m1      (low_m1[c]),
            .period      (period[c]),
            .pwm_level   (level[c]),
            .event_pulse (evt[c]),
            .count       (count[c])
        );
    end

    // read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        for (int c = 0; c < NUM_CH; c++) begin
            if (sel[c]) begin
                unique case (off)
                    OFF_CTRL:   next_rdata = {29'h0, ctrl[c]};
                    OFF_HIGH:   next_rdata = high_m1[c];
                    OFF_LOW:    next_rdata = low_m1[c];
                    OFF_PERIOD: next_rdata = period[c];
                    OFF_VALUE:  next_rdata = count[c];
                    OFF_EOI:    next_rdata = {31'h0, pending[c]};
                    OFF_STATUS: next_rdata = {30'h0, level[c], pending[c]};
                    default:    next_rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // registered outputs
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            rdata   <= 32'h0000_0000;
            pwm_out <= '0;
            irq     <= 1'b0;
        end else begin
            rdata   <= rd ? next_rdata : 32'h0000_0000;
            pwm_out <= level;
            irq     <= |live;
        end
    end
endmodule

// File: include/dpwm_pkg.sv
// How it works
// - two identical counters, each with its own output and its own enable, mode, times, period and mask.
// - each counter is 32 bits wide and advances on the system clock.
// - in pwm mode the high and low durations are set separately, giving frequency and duty.
// - the shortest high and low durations are two clock cycles each.
// - the longest high and low durations are two to the thirty-second clock cycles each.
// - high and low durations step by exactly one clock cycle.
// - in pwm mode every rising and every falling output edge at a phase end raises the interrupt, nothing else does.
// - each counter has its own mask that keeps its events off the interrupt.
// - each counter may instead work as a periodic timer, chosen by its mode bit.
// - the timer period runs from 1 to 4294967296 cycles in one-cycle steps.
// - in timer mode each expiry of the period raises a maskable interrupt.
// - reading a counter's interrupt clear register clears that counter's pending interrupt, unless an event of that counter sets it in the same cycle.
// - a disabled counter neither advances nor raises interrupts.
package dpwm_pkg;
    localparam int unsigned CNT_W    = 32;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned NUM_CH   = 2;
    // per-channel register block stride and offsets within it
    localparam logic [7:0] CH_STRIDE    = 8'h20;
    localparam logic [7:0] OFF_CTRL     = 8'h00; // bit0 enable, bit1 timer mode, bit2 mask
    localparam logic [7:0] OFF_HIGH     = 8'h04; // high time minus one
    localparam logic [7:0] OFF_LOW      = 8'h08; // low time minus one
    localparam logic [7:0] OFF_PERIOD   = 8'h0c; // timer period minus one
    localparam logic [7:0] OFF_VALUE    = 8'h10; // current count, read only
    localparam logic [7:0] OFF_EOI      = 8'h14; // interrupt clear on read
    localparam logic [7:0] OFF_STATUS   = 8'h18; // bit0 raw pending, bit1 output level
    localparam int unsigned CTRL_EN     = 0;
    localparam int unsigned CTRL_TIMER  = 1;
    localparam int unsigned CTRL_MASK   = 2;
    localparam logic [31:0] RST_HIGH    = 32'h0000_0001;
    localparam logic [31:0] RST_LOW     = 32'h0000_0001;
    localparam logic [31:0] RST_PERIOD  = 32'h0000_0000;
    localparam logic [31:0] MIN_TIME_M1 = 32'h0000_0001; // two cycles
    localparam logic [31:0] RST_COUNT   = 32'h0000_0000;
endpackage

// File: rtl/dpwm_channel.sv
`timescale 1ns/1ns
module dpwm_channel
    import dpwm_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              enable,
    input  wire logic              timer_mode,
    input  wire logic [CNT_W-1:0]  high_m1,
    input  wire logic [CNT_W-1:0]  low_m1,
    input  wire logic [CNT_W-1:0]  period,
    output logic                   pwm_level,
    output logic                   event_pulse,
    output logic [CNT_W-1:0]       count
);
    logic [CNT_W-1:0] high_eff;
    logic [CNT_W-1:0] low_eff;
    logic [CNT_W-1:0] limit;
    logic             at_limit;

    // clamp to two-cycle minimum
    assign high_eff = (high_m1 < MIN_TIME_M1) ? MIN_TIME_M1 : high_m1;
    assign low_eff  = (low_m1 < MIN_TIME_M1) ? MIN_TIME_M1 : low_m1;
    // phase length; stored value plus one gives 2..2^32 cycles in pwm mode, 1..2^32 in timer mode
    assign limit    = timer_mode ? period : (pwm_level ? high_eff : low_eff);
    assign at_limit = (count >= limit);

    // counter advance and reload
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            count <= RST_COUNT;
        end else if (!enable) begin
            count <= RST_COUNT;
        end else if (at_limit) begin
            count <= RST_COUNT;
        end else begin
            count <= count + 32'h0000_0001;
        end
    end

    // output level toggles each phase end; starts with a full low phase
    // so that every toggle edge, the first rise too, comes with an event
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pwm_level <= 1'b0;
        end else if (!enable || timer_mode) begin
            pwm_level <= 1'b0;
        end else if (at_limit) begin
            pwm_level <= ~pwm_level;
        end
    end

    // edge or expiry event
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            event_pulse <= 1'b0;
        end else begin
            event_pulse <= enable && at_limit;
        end
    end
endmodule

// File: rtl/dpwm_regs.sv
`timescale 1ns/1ns
module dpwm_regs
    import dpwm_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              wr_en,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              event_in,
    input  wire logic              clear_rd,
    output logic [2:0]             ctrl,
    output logic                   pending
);
    // control register
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ctrl <= 3'h0;
        end else if (wr_en) begin
            ctrl <= wdata[2:0];
        end
    end

    // sticky pending, set wins over read clear
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pending <= 1'b0;
        end else if (event_in) begin
            pending <= 1'b1;
        end else if (clear_rd) begin
            pending <= 1'b0;
        end
    end
endmodule

// File: sim/dpwm_top_sva.sv
`timescale 1ns/1ns
module dpwm_top_sva
    import dpwm_pkg::*;
(
    input wire logic              clock,
    input wire logic              reset_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [NUM_CH-1:0] pwm_out,
    input wire logic              irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // read port, phase length and disabled output rules
    property p_idle; !rd |=> rdata == 0; endproperty
    property p_eoi; rd && addr[4:0] == OFF_EOI[4:0] |=> rdata[31:1] == 0; endproperty
    property p_stat; rd && addr[4:0] == OFF_STATUS[4:0] |=> rdata[31:2] == 0; endproperty
    property p_gap; rd && addr[4:0] == 5'h1c |=> rdata == 0; endproperty
    // a disable or timer-mode write may cut a running phase short
    property p_min0;
        $changed(pwm_out[0])
            && !$past(wr && addr == OFF_CTRL && (!wdata[0] || wdata[1]), 2)
            |=> $stable(pwm_out[0]);
    endproperty
    property p_min1;
        $changed(pwm_out[1])
            && !$past(wr && addr == CH_STRIDE && (!wdata[0] || wdata[1]), 2)
            |=> $stable(pwm_out[1]);
    endproperty
    property p_off0; wr && addr == OFF_CTRL && !wdata[0] |-> ##3 !pwm_out[0]; endproperty
    property p_off1; wr && addr == CH_STRIDE && !wdata[0] |-> ##3 !pwm_out[1]; endproperty
    a_idle: assert property (p_idle) else $error("rdata without read");
    a_eoi: assert property (p_eoi) else $error("clear read upper bits");
    a_stat: assert property (p_stat) else $error("status upper bits");
    a_gap: assert property (p_gap) else $error("unmapped read");
    a_min0: assert property (p_min0) else $error("phase 0 short");
    a_min1: assert property (p_min1) else $error("phase 1 short");
    a_off0: assert property (p_off0) else $error("disabled 0 drives");
    a_off1: assert property (p_off1) else $error("disabled 1 drives");
    // main scenarios reached
    c_irq: cover property ($rose(irq));
    c_pwm: cover property ($rose(pwm_out[1]));
    c_eoi: cover property (rd && addr[4:0] == OFF_EOI[4:0] ##1 rdata[0]);
endmodule
bind dpwm_top dpwm_top_sva u_sva (.clock(clock), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pwm_out(pwm_out), .irq(irq));

// File: sim/dpwm_load.sv
`timescale 1ns/1ns
module dpwm_load (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        drive,
    output logic      [31:0] hi_len,
    output logic      [31:0] lo_len
);
    logic [31:0] run;
    logic        last;
    // length of each completed phase seen by the load
    always_ff @(posedge clock) begin
        last <= drive;
        run  <= (drive != last) ? 32'h1 : run + 32'h1;
        if (!reset_n) begin
            hi_len <= 32'h0;
            lo_len <= 32'h0;
        end else if (drive != last && last) hi_len <= run;
        else if (drive != last) lo_len <= run;
    end
endmodule

// File: sim/test_dual_pwm_timer.sv
`timescale 1ns/1ns
module test_dual_pwm_timer;
    import dpwm_pkg::*;
    logic        clock = 0, reset_n = 0, wr = 0, rd = 0, irq;
    logic [7:0]  addr = 0, bs;
    logic [31:0] wdata = 0, rdata, seed = 32'hb881, p, hl [2], ll [2];
    logic [31:0] hi_len [2], lo_len [2];
    logic [1:0]  pwm_out;
    int          fail_count = 0, check_count = 0, n, a, b;
    dpwm_top dut (.clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pwm_out(pwm_out), .irq(irq));
    for (genvar c = 0; c < 2; c++) begin : g_load
        dpwm_load u_load (.clock(clock), .reset_n(reset_n), .drive(pwm_out[c]),
            .hi_len(hi_len[c]), .lo_len(lo_len[c]));
    end
    initial forever #25 clock = ~clock;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // phase length from a time-minus-one value
    function automatic logic [31:0] ph(input logic [31:0] m);
        return (m == 0) ? 32'h2 : m + 32'h1;
    endfunction
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
        check_count++;
        if (v !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic wr_reg(input logic [7:0] x, input logic [31:0] d);
        @(posedge clock);
        addr <= x;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] x);
        @(posedge clock);
        addr <= x;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
    endtask
    task automatic rc(input string s, input logic [7:0] x, input logic [31:0] e);
        rd_reg(x);
        chk(s, e, rdata);
    endtask
    task automatic wait_irq(input logic v, output int k);
        k = 0;
        while (irq !== v && k < 300) begin
            @(posedge clock);
            #1 k++;
        end
        if (k == 300) begin
            fail_count++;
            stop_test();
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        rc("high", OFF_HIGH, RST_HIGH);
        wr_reg(8'h1c, 32'h1);
        rc("gap", 8'h1c, 32'h0);
        for (int i = 0; i < 4; i++) begin
            for (int c = 0; c < 2; c++) begin
                bs = 8'(c * 32);
                seed = lfsr(seed);
                hl[c] = (i == 0) ? 32'h0 : seed % 6;
                ll[c] = (i == 0) ? 32'h0 : (seed >> 8) % 6;
                wr_reg(bs, 32'h0);
                wr_reg(bs + OFF_HIGH, hl[c]);
                wr_reg(bs + OFF_LOW, ll[c]);
                wr_reg(bs, 32'h1);
            end
            repeat (60) @(posedge clock);
            for (int c = 0; c < 2; c++) begin
                chk("hi", ph(hl[c]), hi_len[c]);
                chk("lo", ph(ll[c]), lo_len[c]);
            end
        end
        wait_irq(1'b1, n);
        rc("eoi", CH_STRIDE + OFF_EOI, 32'h1);
        wr_reg(OFF_CTRL, 32'h5);
        wr_reg(CH_STRIDE, 32'h5);
        repeat (5) @(posedge clock);
        chk("irq", 32'h0, irq);
        rc("eoi", OFF_EOI, 32'h1);
        wr_reg(OFF_CTRL, 32'h0);
        wr_reg(CH_STRIDE, 32'h0);
        rd_reg(OFF_EOI);
        rd_reg(CH_STRIDE + OFF_EOI);
        repeat (20) @(posedge clock);
        rc("stat", OFF_STATUS, 32'h0);
        rc("value", OFF_VALUE, 32'h0);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            p = (i == 0) ? 32'h0 : seed % 8 + 6;
            wr_reg(OFF_PERIOD, p);
            wr_reg(OFF_CTRL, 32'h3);
            wait_irq(1'b1, n);
            rd_reg(OFF_EOI);
            if (i == 0) rc("eoi", OFF_EOI, 32'h1);
            else begin
                wait_irq(1'b0, a);
                wait_irq(1'b1, b);
                chk("tmr", p + 1, 2 + a + b);
            end
            chk("tpin", 32'h0, pwm_out);
            wr_reg(OFF_CTRL, 32'h0);
            rd_reg(OFF_EOI);
        end
        stop_test();
    end
endmodule
